//--- core/fspc_flash_ctrl.sv
// flash sector program control: apb registers and operation sequencer
// Function
// - control register at index F9
// - sector high byte at index F6
// - high byte drives pointer bits 15..8
// - sector low byte at index F7
// - only low byte bit 7 selects sector
// - start bit self-clears when operation ends
`timescale 1ns/100ps
`default_nettype none
module fspc_flash_ctrl
  import fspc_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [FSPC_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic                   pslverr,
  output logic      [31:0]       prdata,
  output logic                   fl_req,
  output logic      [1:0]        fl_op,
  output logic      [15:0]       fl_sector,
  input  wire logic              fl_done,
  input  wire logic              fl_fail,
  output logic                   irq
);
  logic [7:0]  sech_q, secl_q, usr_q, con_q, con_d;
  logic [1:0]  ist_q, ist_d, msk_q;
  logic [31:0] prdata_d;
  fspc_state_t st_q, st_d;
  logic        fail_d;

  wire acc     = psel & penable;
  wire wr      = acc & pwrite;
  wire hit_sh  = paddr == FSPC_ADDR_SECH;
  wire hit_sl  = paddr == FSPC_ADDR_SECL;
  wire hit_us  = paddr == FSPC_ADDR_USR;
  wire hit_cn  = paddr == FSPC_ADDR_CON;
  wire hit_is  = paddr == FSPC_ADDR_IRQST;
  wire hit_mk  = paddr == FSPC_ADDR_IRQMSK;
  wire mapped  = hit_sh | hit_sl | hit_us | hit_cn | hit_is | hit_mk;
  wire [3:0] mode     = con_q[FSPC_MODE_LSB +: 4];
  wire       mode_ok  = mode == FSPC_MODE_PROG || mode == FSPC_MODE_ERAS
                      || mode == FSPC_MODE_LOCK;
  wire       enabled  = usr_q == FSPC_USR_KEY;
  wire       start    = con_q[FSPC_START_BIT] & (st_q == FSPC_IDLE);
  wire       launch   = start & mode_ok & enabled;
  // a start with no valid mode or key ends at once so software never hangs
  wire       reject   = start & ~(mode_ok & enabled);
  wire       finish   = (st_q == FSPC_WAIT) & fl_done;
  wire       op_end   = finish | reject;
  wire       erase_op = mode == FSPC_MODE_ERAS;

  assign pready    = 1'b1;
  assign pslverr   = acc & ~mapped;
  assign fl_req    = st_q == FSPC_BUSY;
  assign fl_sector = {sech_q, secl_q[FSPC_SECL_BIT], 7'h00};
  assign fl_op     = (mode == FSPC_MODE_ERAS) ? FSPC_OP_ERASE :
                     (mode == FSPC_MODE_LOCK) ? FSPC_OP_LOCK  : FSPC_OP_PROG;
  assign irq       = |(ist_q & msk_q);

  always_comb begin
    st_d = st_q;
    case (st_q)
      FSPC_IDLE: if (launch) st_d = FSPC_BUSY;
      FSPC_BUSY: st_d = FSPC_WAIT;
      FSPC_WAIT: if (fl_done) st_d = FSPC_IDLE;
      default:   st_d = FSPC_IDLE;
    endcase
  end

  // mode and start writes are held off while busy; the fail flag is never written by software
  always_comb begin
    con_d = con_q;
    fail_d = con_q[FSPC_FAIL_BIT];
    if (finish && erase_op) begin
      fail_d = fl_fail;
    end
    if (wr && hit_cn && st_q == FSPC_IDLE && !con_q[FSPC_START_BIT]) begin
      con_d = pwdata[7:0];
      con_d[2:1] = FSPC_RST2;
    end
    con_d[FSPC_FAIL_BIT] = fail_d;
    if (op_end) begin
      con_d[FSPC_START_BIT] = 1'b0;
    end
  end

  // set wins over write-one-to-clear
  always_comb begin
    ist_d = ist_q;
    if (wr && hit_is) begin
      ist_d = ist_q & ~pwdata[1:0];
    end
    if (op_end) begin
      ist_d[FSPC_IRQ_DONE] = 1'b1;
    end
    if (finish && erase_op && fl_fail) begin
      ist_d[FSPC_IRQ_FAIL] = 1'b1;
    end
  end

  always_comb begin
    prdata_d = 32'h0000_0000;
    if (hit_sh) prdata_d[7:0] = sech_q;
    if (hit_sl) prdata_d[7:0] = secl_q;
    if (hit_us) prdata_d[7:0] = usr_q;
    if (hit_cn) prdata_d[7:0] = con_q;
    if (hit_is) prdata_d[1:0] = ist_q;
    if (hit_mk) prdata_d[1:0] = msk_q;
  end
  assign prdata = (acc && !pwrite) ? prdata_d : 32'h0000_0000;

  // one short register process per register keeps each write path easy to follow
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sech_q <= FSPC_RST8;
    end else if (wr && hit_sh) begin
      sech_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      secl_q <= FSPC_RST8;
    end else if (wr && hit_sl) begin
      secl_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      usr_q <= FSPC_RST8;
    end else if (wr && hit_us) begin
      usr_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      msk_q <= FSPC_RST2;
    end else if (wr && hit_mk) begin
      msk_q <= pwdata[1:0];
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      con_q <= FSPC_RST8;
    end else begin
      con_q <= con_d;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ist_q <= FSPC_RST2;
    end else begin
      ist_q <= ist_d;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= FSPC_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // sequencer and start bit
  start_clears_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    finish |=> !con_q[FSPC_START_BIT])
    else $error("start bit not cleared");

  reject_clear_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    reject |=> !con_q[FSPC_START_BIT])
    else $error("rejected start not cleared");

  start_held_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (st_q != FSPC_IDLE) |-> con_q[FSPC_START_BIT])
    else $error("start bit dropped while busy");

  busy_wait_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (st_q == FSPC_BUSY) |=> (st_q == FSPC_WAIT))
    else $error("busy not followed by wait");

  wait_hold_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (st_q == FSPC_WAIT && !fl_done) |=> (st_q == FSPC_WAIT))
    else $error("wait left without done");

  done_flag_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    op_end |=> ist_q[FSPC_IRQ_DONE])
    else $error("done flag not set");

  irq_level_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (ist_q[FSPC_IRQ_DONE] && msk_q[FSPC_IRQ_DONE]) |-> irq)
    else $error("unmasked done without irq");

  // mode decode and launch
  bad_mode_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (st_q == FSPC_IDLE && !mode_ok) |=> !fl_req)
    else $error("bad mode launched");

  good_launch_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    launch |=> fl_req ##1 !fl_req)
    else $error("launch missing");

  req_pulse_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    fl_req |=> !fl_req)
    else $error("request longer than one cycle");

  reject_idle_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    reject |=> !fl_req)
    else $error("rejected start launched");

  idle_quiet_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (st_q == FSPC_IDLE) |-> !fl_req)
    else $error("request while idle");

  mode_hold_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (st_q != FSPC_IDLE) |=> $stable(con_q[7:4]))
    else $error("mode changed while busy");

  mode_write_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (wr && hit_cn && st_q == FSPC_IDLE && !con_q[FSPC_START_BIT])
    |=> con_q[7:4] == $past(pwdata[7:4]))
    else $error("mode write lost");

  op_prog_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (mode == FSPC_MODE_PROG) |-> (fl_op == FSPC_OP_PROG))
    else $error("program op code");

  op_erase_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (mode == FSPC_MODE_ERAS) |-> (fl_op == FSPC_OP_ERASE))
    else $error("erase op code");

  op_lock_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (mode == FSPC_MODE_LOCK) |-> (fl_op == FSPC_OP_LOCK))
    else $error("lock op code");

  // erase status bit
  fail_report_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (finish && erase_op) |=> con_q[FSPC_FAIL_BIT] == $past(fl_fail))
    else $error("erase status wrong");

  fail_hold_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    !(finish && erase_op) |=> $stable(con_q[FSPC_FAIL_BIT]))
    else $error("status bit changed");

  fail_write_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (wr && hit_cn && !finish) |=> $stable(con_q[FSPC_FAIL_BIT]))
    else $error("status bit written");

  fail_flag_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (finish && erase_op && fl_fail) |=> ist_q[FSPC_IRQ_FAIL])
    else $error("fail flag not set");

  // register map and sector pointer
  con_rsvd_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    con_q[2:1] == FSPC_RST2)
    else $error("unused control bits set");

  con_read_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (acc && !pwrite && hit_cn) |-> prdata[7:0] == con_q)
    else $error("con read");

  unmapped_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (acc && !mapped) |-> pslverr)
    else $error("unmapped access without error");

  read_zero_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (acc && !pwrite && !mapped) |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  sech_write_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (wr && hit_sh) |=> sech_q == $past(pwdata[7:0]))
    else $error("sech write");

  sech_read_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (acc && !pwrite && hit_sh) |-> prdata[7:0] == sech_q)
    else $error("sech read");

  sector_map_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    fl_sector[15:8] == sech_q && fl_sector[6:0] == 7'h00)
    else $error("sector map");

  secl_write_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (wr && hit_sl) |=> secl_q == $past(pwdata[7:0]))
    else $error("secl write");

  secl_read_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (acc && !pwrite && hit_sl) |-> prdata[7:0] == secl_q)
    else $error("secl read");

  secl_bit_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    fl_sector[FSPC_SECL_BIT] == secl_q[FSPC_SECL_BIT])
    else $error("low bit");

  // enable key
  key_gate_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (start && !enabled) |=> !fl_req)
    else $error("launched without key");

  key_launch_a: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    fl_req |-> $past(enabled))
    else $error("request without key");

  erase_cov_c: cover property (@(posedge clk_sys) finish && erase_op && fl_fail);
  prog_cov_c:  cover property (@(posedge clk_sys) finish && mode == FSPC_MODE_PROG);
  lock_cov_c:  cover property (@(posedge clk_sys) finish && mode == FSPC_MODE_LOCK);
  rej_cov_c:   cover property (@(posedge clk_sys) reject);
  irq_cov_c:   cover property (@(posedge clk_sys) irq);
endmodule
`default_nettype wire

//--- core/fspc_pkg.sv
// package: register map, field layout and codes of the flash sector program control
package fspc_pkg;
  // register indices; the apb byte address is the index times four
  localparam logic [7:0] FSPC_IDX_SECH   = 8'hF6;
  localparam logic [7:0] FSPC_IDX_SECL   = 8'hF7;
  localparam logic [7:0] FSPC_IDX_USR    = 8'hF8;
  localparam logic [7:0] FSPC_IDX_CON    = 8'hF9;
  localparam logic [7:0] FSPC_IDX_IRQST  = 8'hFA;
  localparam logic [7:0] FSPC_IDX_IRQMSK = 8'hFB;
  localparam int         FSPC_AW         = 10;
  localparam logic [9:0] FSPC_ADDR_SECH   = {FSPC_IDX_SECH, 2'b00};
  localparam logic [9:0] FSPC_ADDR_SECL   = {FSPC_IDX_SECL, 2'b00};
  localparam logic [9:0] FSPC_ADDR_USR    = {FSPC_IDX_USR, 2'b00};
  localparam logic [9:0] FSPC_ADDR_CON    = {FSPC_IDX_CON, 2'b00};
  localparam logic [9:0] FSPC_ADDR_IRQST  = {FSPC_IDX_IRQST, 2'b00};
  localparam logic [9:0] FSPC_ADDR_IRQMSK = {FSPC_IDX_IRQMSK, 2'b00};
  localparam logic [7:0] FSPC_RST8      = 8'h00;
  localparam logic [1:0] FSPC_RST2      = 2'h0;
  localparam logic [7:0] FSPC_USR_KEY   = 8'hA5;
  localparam logic [3:0] FSPC_MODE_PROG = 4'h5;
  localparam logic [3:0] FSPC_MODE_ERAS = 4'hA;
  localparam logic [3:0] FSPC_MODE_LOCK = 4'h6;
  localparam int FSPC_START_BIT = 0;
  localparam int FSPC_FAIL_BIT  = 3;
  localparam int FSPC_MODE_LSB  = 4;
  localparam int FSPC_SECL_BIT  = 7;
  // interrupt status: bit0 operation done, bit1 erase failed
  localparam int FSPC_IRQ_DONE  = 0;
  localparam int FSPC_IRQ_FAIL  = 1;
  typedef enum logic [1:0] {
    FSPC_IDLE = 2'b00,
    FSPC_BUSY = 2'b01,
    FSPC_WAIT = 2'b10
  } fspc_state_t;
  typedef enum logic [1:0] {
    FSPC_OP_PROG  = 2'b00,
    FSPC_OP_ERASE = 2'b01,
    FSPC_OP_LOCK  = 2'b10
  } fspc_op_t;
endpackage

//--- testbench/fspc_flash_model.sv
// behavioural flash array answering start pulses after a set latency
`timescale 1ns/100ps
`default_nettype none
module fspc_flash_model (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       fl_req,
  input  wire logic [1:0] fl_op,
  input  wire logic       fail_en,
  input  wire logic [3:0] lat,
  output logic            fl_done,
  output logic            fl_fail
);
  logic [4:0] cnt_q;
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) cnt_q <= 5'h0;
    else if (fl_req) cnt_q <= {1'b0, lat} + 5'h1;
    else if (cnt_q != 5'h0) cnt_q <= cnt_q - 5'h1;
  end
  assign fl_done = (cnt_q == 5'h1);
  // outside done the fail line carries no meaning, so it follows bit 0 of the latency counter
  assign fl_fail = fl_done ? (fail_en && fl_op == 2'h1) : cnt_q[0];
endmodule
`default_nettype wire

//--- testbench/tb.sv
// self-checking bench for the flash sector program control
`timescale 1ns/100ps
`default_nettype none
module tb;
  import fspc_pkg::*;
  logic        clk_sys, sys_rst, psel, penable, pwrite, pready, pslverr, fail_en;
  logic        fl_req, fl_done, fl_fail, irq, last_err;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0]  fl_op, seen_op;
  logic [15:0] fl_sector, seen_sec;
  logic [3:0]  lat;
  int          fail_count, checks_done, cycles, nreq, n0;
  logic [3:0]  md_t [5] = '{4'hA, 4'hA, 4'h6, 4'h5, 4'h3};
  logic [7:0]  lo_t [5] = '{8'h80, 8'h7F, 8'hFF, 8'h01, 8'h80};
  logic [1:0]  op_t [5] = '{2'h1, 2'h1, 2'h2, 2'h0, 2'h0};
  logic        fl_t [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0};
  logic        f3_t [5] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
  logic        rq_t [5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
  logic [9:0]  rst_a [6] = '{FSPC_ADDR_SECH, FSPC_ADDR_SECL, FSPC_ADDR_USR, FSPC_ADDR_CON,
                             FSPC_ADDR_IRQST, FSPC_ADDR_IRQMSK};
  fspc_flash_ctrl i_fspc_flash_ctrl (.clk_sys, .sys_rst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .pslverr, .prdata, .fl_req, .fl_op, .fl_sector, .fl_done, .fl_fail, .irq);
  fspc_flash_model i_fspc_flash_model (.clk_sys, .sys_rst, .fl_req, .fl_op, .fail_en, .lat,
    .fl_done, .fl_fail);
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (fl_req === 1'b1) begin
      nreq++;
      seen_op = fl_op;
      seen_sec = fl_sector;
    end
    if (cycles == 4000) begin
      fail_count++;
      final_report();
    end
  end
  task automatic final_report;
    if (fail_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // poke rewrites control mid-operation, which must be ignored
  task automatic run_op(input logic [7:0] key, hi, lo, input logic [3:0] m, input logic poke);
    apb(1'b1, FSPC_ADDR_USR, {24'h0, key});
    apb(1'b1, FSPC_ADDR_SECH, {24'h0, hi});
    apb(1'b1, FSPC_ADDR_SECL, {24'h0, lo});
    n0 = nreq;
    apb(1'b1, FSPC_ADDR_CON, {24'h0, m, 4'h1});
    if (poke) apb(1'b1, FSPC_ADDR_CON, 32'h0000_00A1);
    rd = 32'h1;
    while (rd[0] === 1'b1) apb(1'b0, FSPC_ADDR_CON, 32'h0);
  endtask
  initial begin
    {psel, penable, pwrite, fail_en, sys_rst} = 5'h01;
    paddr = 10'h0;
    pwdata = 32'h0;
    lat = 4'h2;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      fail_en <= fl_t[i];
      run_op(FSPC_USR_KEY, 8'(i + 1), lo_t[i], md_t[i], 1'b0);
      chk(rd[7:0], {md_t[i], f3_t[i], 3'h0});
      chk(nreq - n0, rq_t[i]);
      if (rq_t[i]) chk({seen_op, seen_sec}, {op_t[i], 8'(i + 1), lo_t[i][7], 7'h0});
      apb(1'b0, FSPC_ADDR_SECL, 32'h0);
      chk(rd, {24'h0, lo_t[i]});
      apb(1'b0, FSPC_ADDR_IRQST, 32'h0);
      chk(rd[1:0], {md_t[i] == FSPC_MODE_ERAS && fl_t[i], 1'b1});
      apb(1'b1, FSPC_ADDR_IRQST, 32'h3);
    end
    apb(1'b1, FSPC_ADDR_IRQMSK, 32'h1);
    run_op(8'h5A, 8'hC3, 8'h00, 4'h5, 1'b0);
    chk(nreq - n0, 0);
    #1 chk(irq, 1'b1);
    apb(1'b1, FSPC_ADDR_IRQST, 32'h1);
    #1 chk(irq, 1'b0);
    apb(1'b1, FSPC_ADDR_IRQMSK, 32'h0);
    lat <= 4'h9;
    run_op(FSPC_USR_KEY, 8'hC3, 8'h00, 4'h5, 1'b1);
    chk({irq, seen_op, rd[7:4]}, {1'b0, 2'h0, 4'h5});
    apb(1'b0, FSPC_ADDR_SECH, 32'h0);
    chk(rd, 32'h0000_00C3);
    apb(1'b0, 10'h3FC, 32'h0);
    chk({last_err, pready}, 2'b11);
    chk(rd, 32'h0);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    chk({irq, fl_req}, 2'b00);
    foreach (rst_a[k]) begin
      apb(1'b0, rst_a[k], 32'h0);
      chk(rd, 32'h0);
    end
    final_report();
  end
endmodule
`default_nettype wire
